// >>> hw/oag_pkg.sv
/*
 Package for the operand address generator: widths, register indices,
 operand sizes and the mode, data type and access type encodings.
 Assumes one processor clock and a 32-bit byte-addressed memory path.
*/
package oag_pkg;
  localparam int ADDR_W = 32;
  localparam int NUM_REGS = 16;
  localparam int CC_W = 4;
  localparam int CTX_WORDS = 17;
  localparam logic [3:0] PC_IDX = 4'hf;
  localparam logic [3:0] AP_IDX = 4'hc;
  localparam logic [4:0] CTX_LAST = 5'h10;
  localparam logic [31:0] SIZE_BYTE = 32'h1;
  localparam logic [31:0] SIZE_WORD = 32'h2;
  localparam logic [31:0] SIZE_LONG = 32'h4;
  localparam logic [31:0] SIZE_QUAD = 32'h8;
  localparam logic [31:0] REG_RESET = 32'h0;
  localparam logic [3:0] CC_RESET = 4'h0;
  localparam int BYTE_SIGN_BIT = 7;
  localparam int WORD_SIGN_BIT = 15;

  typedef enum logic [2:0] {
    MD_AUTOINC, MD_AUTODEC, MD_AUTOINC_DEF, MD_DISP, MD_BRANCH
  } oag_mode_e;

  typedef enum logic [2:0] {
    DT_BYTE, DT_WORD, DT_LONG, DT_FLOAT, DT_QUAD, DT_DFLOAT
  } oag_dtype_e;

  typedef enum logic [2:0] {
    AC_READ, AC_WRITE, AC_MODIFY, AC_ADDRESS, AC_BRANCH
  } oag_access_e;

  typedef enum logic [1:0] {
    DW_BYTE, DW_WORD, DW_LONG
  } oag_dispw_e;

  // Operand size in bytes for a data type
  function automatic logic [31:0] oag_size_bytes(input oag_dtype_e dt);
    case (dt)
      DT_BYTE: oag_size_bytes = SIZE_BYTE;
      DT_WORD: oag_size_bytes = SIZE_WORD;
      DT_QUAD, DT_DFLOAT: oag_size_bytes = SIZE_QUAD;
      default: oag_size_bytes = SIZE_LONG;
    endcase
  endfunction : oag_size_bytes

  // Shift amount that scales an index by the operand size
  function automatic logic [1:0] oag_size_shift(input oag_dtype_e dt);
    case (dt)
      DT_BYTE: oag_size_shift = 2'h0;
      DT_WORD: oag_size_shift = 2'h1;
      DT_QUAD, DT_DFLOAT: oag_size_shift = 2'h3;
      default: oag_size_shift = 2'h2;
    endcase
  endfunction : oag_size_shift

  // Width in which a read operand is widened for a data type
  function automatic oag_dispw_e oag_read_width(input oag_dtype_e dt);
    case (dt)
      DT_BYTE: oag_read_width = DW_BYTE;
      DT_WORD: oag_read_width = DW_WORD;
      default: oag_read_width = DW_LONG;
    endcase
  endfunction : oag_read_width
endpackage : oag_pkg

// >>> hw/oag_sign_ext.sv
/*
 Widens a byte, word or longword to 32 bits, signed or unsigned.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module oag_sign_ext (
  input wire logic [31:0] raw,
  input wire oag_pkg::oag_dispw_e width,
  input wire logic signExt,
  output logic [31:0] value
);
  import oag_pkg::*;

  // Byte: bit 7 is the sign when signed, else zero fill
  always_comb begin
    case (width)
      DW_BYTE: value = {{24{signExt & raw[BYTE_SIGN_BIT]}}, raw[7:0]};
      DW_WORD: value = {{16{signExt & raw[WORD_SIGN_BIT]}}, raw[15:0]};
      default: value = raw;
    endcase
  end
endmodule : oag_sign_ext
`default_nettype wire

// >>> hw/oag_index_scale.sv
/*
 Scales an index register value by the operand size of the data type.
 Purely combinational; overflow past 32 bits wraps.
*/
`timescale 1ns/1ps
`default_nettype none
module oag_index_scale (
  input wire logic [31:0] index,
  input wire oag_pkg::oag_dtype_e dtype,
  input wire logic enable,
  output logic [31:0] offset
);
  import oag_pkg::*;

  // Offset follows from the known operand size
  always_comb begin
    if (enable) begin
      offset = index << oag_size_shift(dtype);
    end else begin
      offset = 32'h0;
    end
  end
endmodule : oag_index_scale
`default_nettype wire

// >>> hw/oag_operand_address_generator.sv
/*
 Operand specifier evaluation: effective address, register side effects,
 deferred pointer fetch, operand read, result store, condition codes and
 process context save/load through one longword memory port.
 Assumes the memory side answers each request with memAck plus fault flags,
 and that all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module oag_operand_address_generator (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic specGo,
  input wire oag_pkg::oag_mode_e specMode,
  input wire logic [3:0] specReg,
  input wire oag_pkg::oag_dtype_e specType,
  input wire oag_pkg::oag_access_e specAccess,
  input wire logic specIndexed,
  input wire logic [3:0] specIndexReg,
  input wire oag_pkg::oag_dispw_e dispWidth,
  input wire logic [31:0] extData,
  input wire logic [2:0] extLen,
  input wire logic signedOperand,
  input wire logic storeGo,
  input wire logic [31:0] storeData,
  input wire logic callGo,
  input wire logic [31:0] callArgBase,
  input wire logic ccWrite,
  input wire logic [3:0] ccIn,
  input wire logic ctxSaveGo,
  input wire logic ctxLoadGo,
  input wire logic [31:0] ctxBase,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  input wire logic memUnmapped,
  input wire logic memNoAccess,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  output logic busy,
  output logic done,
  output logic accessViolation,
  output logic [31:0] operandAddr,
  output logic [31:0] operandData,
  output logic [3:0] condCodes,
  output logic [31:0] programCounter,
  output logic [31:0] argumentListPointer
);
  import oag_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEFER, ST_OPRD, ST_STORE, ST_CTX_SAVE, ST_CTX_LOAD
  } oag_state_e;

  oag_state_e state_r;
  logic [31:0] regs_r [NUM_REGS];
  logic [3:0] cc_r;
  logic [4:0] ctxCnt_r;
  logic [31:0] idxOff_r;
  logic [31:0] ea_r;
  logic [31:0] rdExt;
  logic [31:0] dispExt;
  logic [31:0] idxOff;
  logic [31:0] eaNxt;
  logic [31:0] size;
  logic [31:0] base;
  logic [31:0] pcAfterExt;
  logic regWe;
  logic [3:0] regWIdx;
  logic [31:0] regWVal;
  logic accept;
  logic needDefer;
  logic fault;
  oag_dtype_e type_r;
  oag_access_e access_r;

  // Displacement widening, always signed
  oag_sign_ext u_disp_ext (
    .raw(extData),
    .width(dispWidth),
    .signExt(1'b1),
    .value(dispExt)
  );

  // Read operand interpretation for byte and word types
  oag_sign_ext u_read_ext (
    .raw(memRdata),
    .width(oag_read_width(type_r)),
    .signExt(signedOperand),
    .value(rdExt)
  );

  // Index offset from the index register
  oag_index_scale u_index (
    .index(regs_r[specIndexReg]),
    .dtype(specType),
    .enable(specIndexed),
    .offset(idxOff)
  );

  assign accept = specGo && state_r == ST_IDLE;
  assign fault = memUnmapped | memNoAccess;
  assign size = oag_size_bytes(specType);
  assign base = regs_r[specReg];
  assign pcAfterExt = regs_r[PC_IDX] + {29'h0, extLen};
  assign needDefer = specMode == MD_AUTOINC_DEF && specReg != PC_IDX;

  // Effective address and register side effect of one specifier
  always_comb begin
    eaNxt = base;
    regWe = 1'b0;
    regWIdx = specReg;
    regWVal = base;
    case (specMode)
      MD_AUTOINC: begin
        eaNxt = base + idxOff;
        regWe = 1'b1;
        regWVal = base + size;
      end
      MD_AUTODEC: begin
        eaNxt = base - size + idxOff;
        regWe = 1'b1;
        regWVal = base - size;
      end
      MD_AUTOINC_DEF: begin
        regWe = 1'b1;
        if (specReg == PC_IDX) begin
          eaNxt = extData + idxOff;
          regWVal = base + SIZE_LONG;
        end else begin
          eaNxt = base;
          regWVal = base + SIZE_LONG;
        end
      end
      MD_DISP: begin
        if (specReg == PC_IDX) begin
          eaNxt = pcAfterExt + dispExt + idxOff;
          regWe = 1'b1;
          regWIdx = PC_IDX;
          regWVal = pcAfterExt;
        end else begin
          eaNxt = base + dispExt + idxOff;
        end
      end
      MD_BRANCH: begin
        eaNxt = pcAfterExt + dispExt;
        regWe = 1'b1;
        regWIdx = PC_IDX;
        regWVal = pcAfterExt;
      end
      default: begin
        eaNxt = base;
      end
    endcase
  end

  // General registers; specifier updates land at once for the next one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (accept && regWe) begin
      regs_r[regWIdx] <= regWVal;
    end else if (state_r == ST_CTX_LOAD && memAck && !fault && ctxCnt_r != CTX_LAST) begin
      regs_r[ctxCnt_r[3:0]] <= memRdata;
    end else if (callGo && state_r == ST_IDLE) begin
      regs_r[AP_IDX] <= callArgBase;
    end
  end

  // Condition codes of the flags word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cc_r <= CC_RESET;
    end else if (state_r == ST_CTX_LOAD && memAck && !fault && ctxCnt_r == CTX_LAST) begin
      cc_r <= memRdata[CC_W-1:0];
    end else if (ccWrite) begin
      cc_r <= ccIn;
    end
  end

  // Visible copies of PC, argument pointer and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      programCounter <= REG_RESET;
      argumentListPointer <= REG_RESET;
      condCodes <= CC_RESET;
    end else begin
      programCounter <= regs_r[PC_IDX];
      argumentListPointer <= regs_r[AP_IDX];
      condCodes <= cc_r;
    end
  end

  // Sequencer for memory references, results and faults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 32'h0;
      memWdata <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
      accessViolation <= 1'b0;
      operandAddr <= 32'h0;
      operandData <= 32'h0;
      ea_r <= 32'h0;
      idxOff_r <= 32'h0;
      ctxCnt_r <= 5'h0;
      type_r <= DT_LONG;
      access_r <= AC_READ;
    end else begin
      done <= 1'b0;
      accessViolation <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (specGo) begin
            type_r <= specType;
            access_r <= specAccess;
            idxOff_r <= idxOff;
            ea_r <= eaNxt;
            operandAddr <= eaNxt;
            if (needDefer) begin
              state_r <= ST_DEFER;
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= eaNxt;
              busy <= 1'b1;
            end else if (specAccess == AC_READ || specAccess == AC_MODIFY) begin
              state_r <= ST_OPRD;
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= eaNxt;
              busy <= 1'b1;
            end else begin
              done <= 1'b1;
            end
          end else if (storeGo) begin
            state_r <= ST_STORE;
            memReq <= 1'b1;
            memWe <= 1'b1;
            memAddr <= ea_r;
            memWdata <= storeData;
            busy <= 1'b1;
          end else if (ctxSaveGo) begin
            state_r <= ST_CTX_SAVE;
            ctxCnt_r <= 5'h0;
            memReq <= 1'b1;
            memWe <= 1'b1;
            memAddr <= ctxBase;
            memWdata <= regs_r[0];
            busy <= 1'b1;
          end else if (ctxLoadGo) begin
            state_r <= ST_CTX_LOAD;
            ctxCnt_r <= 5'h0;
            memReq <= 1'b1;
            memWe <= 1'b0;
            memAddr <= ctxBase;
            busy <= 1'b1;
          end
        end
        ST_DEFER: begin
          if (memAck) begin
            if (fault) begin
              state_r <= ST_IDLE;
              memReq <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              accessViolation <= 1'b1;
            end else if (access_r == AC_READ || access_r == AC_MODIFY) begin
              state_r <= ST_OPRD;
              ea_r <= memRdata + idxOff_r;
              operandAddr <= memRdata + idxOff_r;
              memAddr <= memRdata + idxOff_r;
            end else begin
              state_r <= ST_IDLE;
              ea_r <= memRdata + idxOff_r;
              operandAddr <= memRdata + idxOff_r;
              memReq <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end
        ST_OPRD, ST_STORE: begin
          if (memAck) begin
            state_r <= ST_IDLE;
            memReq <= 1'b0;
            memWe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            accessViolation <= fault;
            if (state_r == ST_OPRD && !fault) begin
              operandData <= rdExt;
            end
          end
        end
        ST_CTX_SAVE, ST_CTX_LOAD: begin
          if (memAck) begin
            if (fault || ctxCnt_r == CTX_LAST) begin
              state_r <= ST_IDLE;
              memReq <= 1'b0;
              memWe <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              accessViolation <= fault;
            end else begin
              ctxCnt_r <= ctxCnt_r + 5'h1;
              memAddr <= memAddr + SIZE_LONG;
              if (ctxCnt_r + 5'h1 == CTX_LAST) begin
                memWdata <= {28'h0, cc_r};
              end else begin
                memWdata <= regs_r[ctxCnt_r[3:0] + 4'h1];
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          memReq <= 1'b0;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : oag_operand_address_generator
`default_nettype wire

// >>> bench/oag_checker_properties.sv
/*
 Checker for the operand address generator: memory request, fault and
 no-reference relations on the top module's ports.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module oag_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic specGo,
  input var oag_pkg::oag_mode_e specMode,
  input var oag_pkg::oag_access_e specAccess,
  input wire logic memAck,
  input wire logic memUnmapped,
  input wire logic memNoAccess,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic busy,
  input wire logic done,
  input wire logic accessViolation
);
  import oag_pkg::*;
  logic fault;
  // Either fault flag returned with an answer
  assign fault = memUnmapped || memNoAccess;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command taken while idle, and memory answer taken
  sequence s_take;
    specGo && !busy;
  endsequence
  sequence s_ack;
    memReq && memAck;
  endsequence
  chk_fault_violation: assert property (s_ack ##0 fault |=> accessViolation && done)
    else $error("fault answer gave no violation");
  chk_clean_no_fault: assert property (s_ack ##0 !fault |=> !accessViolation)
    else $error("violation without fault");
  chk_violation_done: assert property (accessViolation |-> done)
    else $error("violation outside done");
  chk_read_issues: assert property (s_take ##0 specAccess == AC_READ |=> memReq && busy)
    else $error("read operand made no request");
  chk_branch_no_ref: assert property (s_take ##0 specAccess == AC_BRANCH |=> done && !memReq)
    else $error("branch operand touched memory");
  chk_address_no_ref: assert property (s_take ##0 specAccess == AC_ADDRESS &&
    specMode != MD_AUTOINC_DEF |=> done && !memReq)
    else $error("address operand touched memory");
  chk_req_holds: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("request dropped before answer");
  chk_idle_no_req: assert property (!busy |-> !memReq)
    else $error("request while idle");
endmodule : oag_checker
bind oag_operand_address_generator oag_checker i_chk (.clk(clk), .sys_rst(sys_rst),
  .specGo(specGo), .specMode(specMode), .specAccess(specAccess), .memAck(memAck),
  .memUnmapped(memUnmapped), .memNoAccess(memNoAccess), .memReq(memReq),
  .memAddr(memAddr), .busy(busy), .done(done), .accessViolation(accessViolation));
`default_nettype wire

// >>> bench/tb_oag_operand_address_generator.sv
/*
 Self-checking bench for the operand address generator: a table of
 specifiers, then store, fault, call, flags and context tests.
 Assumes memory answers a request one cycle later, or two when it directly follows an answer, with data addr+1000h.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_oag_operand_address_generator;
  import oag_pkg::*;
  typedef struct {
    oag_mode_e m; logic [3:0] r; oag_dtype_e t; oag_access_e a; oag_dispw_e w;
    logic [31:0] x; logic [2:0] l; logic s; logic [3:0] ix;
    logic [31:0] ea; logic [31:0] d; logic [31:0] pc;
  } oag_tbrow_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] goV = 4'h0;
  oag_mode_e specMode = MD_AUTOINC;
  logic [3:0] specReg = 4'h0;
  oag_dtype_e specType = DT_LONG;
  oag_access_e specAccess = AC_READ;
  logic specIndexed = 1'b0;
  logic [3:0] specIndexReg = 4'h0;
  oag_dispw_e dispWidth = DW_BYTE;
  logic [31:0] extData = 32'h0, storeData = 32'h0, callArgBase = 32'h0, ctxBase = 32'h0;
  logic [2:0] extLen = 3'h0;
  logic signedOperand = 1'b0, callGo = 1'b0, ccWrite = 1'b0;
  logic [3:0] ccIn = 4'h0;
  logic memAck = 1'b0, memUnmapped = 1'b0, memNoAccess = 1'b0;
  logic [31:0] memRdata = 32'h0;
  logic memReq, memWe, busy, done, accessViolation;
  logic [31:0] memAddr, memWdata, operandAddr, operandData, programCounter, apCopy;
  logic [3:0] condCodes;
  logic [1:0] fk = 2'h0;
  logic sawAv;
  logic [31:0] fA, fD;
  int wN = 0, checks = 0, miscompares = 0;
  oag_tbrow_s rows [15];

  oag_operand_address_generator i_dut (.clk(clk), .sys_rst(sys_rst), .specGo(goV[0]),
    .specMode(specMode), .specReg(specReg), .specType(specType), .specAccess(specAccess),
    .specIndexed(specIndexed), .specIndexReg(specIndexReg), .dispWidth(dispWidth),
    .extData(extData), .extLen(extLen), .signedOperand(signedOperand), .storeGo(goV[1]),
    .storeData(storeData), .callGo(callGo), .callArgBase(callArgBase), .ccWrite(ccWrite),
    .ccIn(ccIn), .ctxSaveGo(goV[2]), .ctxLoadGo(goV[3]), .ctxBase(ctxBase),
    .memAck(memAck), .memRdata(memRdata), .memUnmapped(memUnmapped),
    .memNoAccess(memNoAccess), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .busy(busy), .done(done), .accessViolation(accessViolation),
    .operandAddr(operandAddr), .operandData(operandData), .condCodes(condCodes),
    .programCounter(programCounter), .argumentListPointer(apCopy));

  // Clock, 20 ns period
  always #10 clk = ~clk;

  // Memory: answers a request one cycle later, or two when it directly follows an answer; logs writes
  always @(posedge clk) begin
    #1;
    if (memReq === 1'b1 && memAck === 1'b0) begin
      memAck = 1'b1;
      memRdata = memAddr + 32'h1000;
      {memNoAccess, memUnmapped} = fk;
      if (memWe === 1'b1) begin
        if (wN == 0) begin
          fA = memAddr;
          fD = memWdata;
        end
        wN++;
      end
    end else begin
      memAck = 1'b0;
      {memNoAccess, memUnmapped} = 2'h0;
    end
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // Pulse one command, wait for done, let register copies settle
  task automatic cmd(input int k);
    int n;
    goV[k] = 1'b1;
    tick;
    goV[k] = 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) tick;
    sawAv = accessViolation;
    chk(done === 1'b1, "no done");
    tick;
    tick;
  endtask : cmd

  task automatic spec(input oag_tbrow_s r);
    specMode = r.m; specReg = r.r; specType = r.t; specAccess = r.a; dispWidth = r.w;
    extData = r.x; extLen = r.l; signedOperand = r.s;
    specIndexed = (r.ix != 4'h0);
    specIndexReg = r.ix;
    cmd(0);
  endtask : spec

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end

  // Registers after load from base 0: Rk = 4k+1000h, PC 103ch
  initial begin
    rows = '{
      '{MD_BRANCH, 0, DT_BYTE, AC_BRANCH, DW_BYTE, 'hf0, 1, 0, 0, 'h102d, 0, 'h103d},
      '{MD_BRANCH, 0, DT_WORD, AC_BRANCH, DW_WORD, 'h100, 2, 0, 0, 'h113f, 0, 'h103f},
      '{MD_AUTOINC_DEF, 15, DT_LONG, AC_READ, DW_LONG, 'h4000, 4, 0, 0, 'h4000, 'h5000,
        'h1043},
      '{MD_AUTOINC, 3, DT_LONG, AC_READ, DW_LONG, 0, 0, 0, 0, 'h100c, 'h200c, 0},
      '{MD_AUTOINC, 3, DT_BYTE, AC_READ, DW_LONG, 0, 0, 0, 0, 'h1010, 'h10, 0},
      '{MD_AUTODEC, 3, DT_WORD, AC_READ, DW_LONG, 0, 0, 0, 0, 'h100f, 'h200f, 0},
      '{MD_AUTODEC, 3, DT_QUAD, AC_ADDRESS, DW_LONG, 0, 0, 0, 0, 'h1007, 0, 0},
      '{MD_AUTOINC, 3, DT_BYTE, AC_ADDRESS, DW_LONG, 0, 0, 0, 0, 'h1007, 0, 0},
      '{MD_AUTOINC_DEF, 4, DT_LONG, AC_READ, DW_LONG, 0, 0, 0, 0, 'h2010, 'h3010, 0},
      '{MD_AUTOINC, 4, DT_LONG, AC_ADDRESS, DW_LONG, 0, 0, 0, 0, 'h1014, 0, 0},
      '{MD_DISP, 5, DT_LONG, AC_READ, DW_BYTE, 'hfc, 1, 0, 0, 'h1010, 'h2010, 0},
      '{MD_DISP, 0, DT_BYTE, AC_READ, DW_WORD, 'h80, 2, 1, 0, 'h1080, 'hffffff80, 0},
      '{MD_DISP, 0, DT_BYTE, AC_READ, DW_WORD, 'h80, 2, 0, 0, 'h1080, 'h80, 0},
      '{MD_DISP, 0, DT_LONG, AC_ADDRESS, DW_BYTE, 0, 1, 0, 1, 'h5010, 0, 0},
      '{MD_DISP, 0, DT_WORD, AC_ADDRESS, DW_BYTE, 0, 1, 0, 1, 'h3008, 0, 0}};
    repeat (6) @(posedge clk);
    #1;
    chk(memReq === 1'b0 && busy === 1'b0 && done === 1'b0 && programCounter === 32'h0,
      "reset state");
    sys_rst = 1'b0;
    cmd(3);
    chk(programCounter === 32'h103c && apCopy === 32'h1030, "context load");
    foreach (rows[i]) begin
      spec(rows[i]);
      chk(operandAddr === rows[i].ea, "address");
      if (rows[i].a == AC_READ) chk(operandData === rows[i].d, "data");
      if (rows[i].pc != 32'h0) chk(programCounter === rows[i].pc, "pc");
      chk(sawAv === 1'b0, "spurious violation");
    end
    // Store goes to the saved write address after the increment
    spec('{MD_AUTOINC, 3, DT_LONG, AC_WRITE, DW_LONG, 0, 0, 0, 0, 0, 0, 0});
    chk(operandAddr === 32'h1008, "write address");
    storeData = 32'hcafe0001;
    wN = 0;
    cmd(1);
    chk(wN == 1 && fA === 32'h1008 && fD === 32'hcafe0001, "store");
    spec('{MD_AUTOINC, 3, DT_BYTE, AC_ADDRESS, DW_LONG, 0, 0, 0, 0, 0, 0, 0});
    chk(operandAddr === 32'h100c, "updated register");
    // Both fault kinds
    for (int k = 1; k < 3; k++) begin
      fk = 2'(k);
      spec('{MD_AUTOINC, 5, DT_LONG, AC_READ, DW_LONG, 0, 0, 0, 0, 0, 0, 0});
      chk(sawAv === 1'b1, "fault not reported");
      fk = 2'h0;
    end
    callArgBase = 32'h00abc000;
    callGo = 1'b1;
    tick;
    callGo = 1'b0;
    ccIn = 4'ha;
    ccWrite = 1'b1;
    tick;
    ccWrite = 1'b0;
    repeat (3) tick;
    chk(apCopy === 32'h00abc000, "argument list pointer");
    chk(condCodes === 4'ha, "condition codes");
    ctxBase = 32'h8000;
    wN = 0;
    cmd(2);
    chk(wN == 17 && fA === 32'h8000 && fD === 32'h1000, "context save");
    // Reset in mid-run clears copies and results, then a first branch
    sys_rst = 1'b1;
    repeat (2) tick;
    sys_rst = 1'b0;
    repeat (2) tick;
    chk(programCounter === 32'h0 && apCopy === 32'h0 && condCodes === 4'h0 &&
      operandAddr === 32'h0 && busy === 1'b0 && memReq === 1'b0, "mid-run reset");
    spec('{MD_BRANCH, 0, DT_BYTE, AC_BRANCH, DW_BYTE, 'h04, 1, 0, 0, 0, 0, 0});
    chk(operandAddr === 32'h5 && programCounter === 32'h1, "branch after reset");
    finish_test;
  end
endmodule : tb_oag_operand_address_generator
`default_nettype wire
